// *** src/pda_top.sv ***
// Post divider, pulse swallower, phase sampler and status pin with AXI4-Lite registers
//
// Contract
// RL1: Post divider is three cascaded stages, each with its own modulus.
// RL2: Overall division ratio equals the product of the three moduli.
// RL3: Output keeps a nominal half duty cycle, odd moduli included.
// RL4: Swallower deletes one VCO pulse before it reaches the post divider.
// RL5: Each zero-to-one request edge delays the output by one VCO period.
// RL6: Feedback source select picks VCO or post divider output for feedback.
// RL7: Host sets feedback modulus to a multiple of post ratio in loop.
// RL8: Alignment flag toggles whenever output and feedback phases align.
// RL9: Output clock is sampled by the feedback clock to set the flag.
// RL10: Host steps one slip at a time until the flag changes.
// RL11: Status select code high-one low-zero enters alignment flag mode.
// RL12: In alignment mode with push-pull enabled the flag drives the pin.
// RL13: In alignment mode reading the upper select bit returns the flag.
// RL14: Both select bits one route the feedback divider clock to the pin.
// RL15: The status pin is driven only while push-pull enable is one.
// RL16: Four-bit coarse code selects crystal load capacitance.
// RL17: Fine-tune enable bit switches voltage fine tuning on or off.
// RL18: Select code zero reports crystal loop lock, low meaning unlocked.
// RL19: Select code zero-one reports the out-of-range direction of the loop.
// RL20: Swallow request is edge detected in the VCO domain, one pulse each.
`timescale 1ns/1ps
`default_nettype none
`include "pda_params.svh"

module pda_top (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [`PDA_ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [`PDA_DATA_W-1:0]       s_axi_wdata,
  input  wire logic [`PDA_DATA_W/8-1:0]     s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [`PDA_ADDR_W-1:0]       s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [`PDA_DATA_W-1:0]            s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic                         xtal_lock_ok,
  input  wire logic                         xtal_range_high,
  input  wire logic                         lock_status_pin_i,
  output logic                              lock_status_pin_o,
  output logic                              lock_status_pin_oe,
  output logic                              differential_clock_out_p,
  output logic                              differential_clock_out_n,
  output logic [`PDA_COARSE_W-1:0]          crystal_coarse_tune_code,
  output logic                              crystal_fine_tune_enable
);

  pda_pkg::pda_state_t s_q;
  pda_pkg::pda_state_t s_d;

  // Internal tick and clock levels of the divider chain
  logic                       vco_en;
  logic                       p1_tick;
  logic                       p2_tick;
  logic                       p3_tick;
  logic                       p1_level;
  logic                       p2_level;
  logic                       out_level;
  logic                       fb_src_tick;
  logic                       fb_tick;
  logic                       fb_level;

  // Control fields taken from the registers
  logic                       swallow_req;
  logic                       feedback_source_select;
  logic                       pushpull_en;
  pda_pkg::pda_stat_mode_t    stat_mode;
  logic [`PDA_DIV_W-1:0]      np1;
  logic [`PDA_DIV_W-1:0]      np2;
  logic [`PDA_DIV_W-1:0]      np3;
  logic [`PDA_FB_W-1:0]       nfb;

  // Bus write and read helpers
  logic                       aw_take;
  logic                       w_take;
  logic                       have_aw;
  logic                       have_w;
  logic [`PDA_ADDR_W-1:0]     wr_addr;
  logic [`PDA_DATA_W-1:0]     wr_data;
  logic [`PDA_DATA_W/8-1:0]   wr_strb;
  logic                       status_bit;
  logic [`PDA_DATA_W-1:0]     ctrl_rd;
  logic [`PDA_DATA_W-1:0]     status_rd;

  // Byte-lane merge of a write into an existing register value
  function automatic logic [`PDA_DATA_W-1:0] merge_bytes(
    input logic [`PDA_DATA_W-1:0]   old_v,
    input logic [`PDA_DATA_W-1:0]   new_v,
    input logic [`PDA_DATA_W/8-1:0] strb,
    input logic [`PDA_DATA_W-1:0]   mask
  );
    logic [`PDA_DATA_W-1:0] r;
    r = old_v;
    for (int i = 0; i < `PDA_DATA_W/8; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r & mask;
  endfunction

  // Field extraction from the control and divider registers
  assign swallow_req            = s_q.ctrl[`PDA_CTRL_SWALLOW];
  assign feedback_source_select = s_q.ctrl[`PDA_CTRL_FBSEL];
  assign pushpull_en            = s_q.ctrl[`PDA_CTRL_PUSHPULL];
  assign stat_mode              = pda_pkg::pda_stat_mode_t'(
                                    s_q.ctrl[`PDA_CTRL_STAT_HI:`PDA_CTRL_STAT_LO]);
  assign np1                    = s_q.div[`PDA_DIV_P1 +: `PDA_DIV_W];
  assign np2                    = s_q.div[`PDA_DIV_P2 +: `PDA_DIV_W];
  assign np3                    = s_q.div[`PDA_DIV_P3 +: `PDA_DIV_W];
  assign nfb                    = s_q.fbdiv[`PDA_FB_W-1:0];

  // RL4: gate VCO ticks
  pda_swallow u_swallow (
    .aclk    (aclk),
    .aresetn (aresetn),
    .request (swallow_req),
    .vco_en  (vco_en)
  );

  // RL1: three cascaded stages
  pda_div_stage #(.W(`PDA_DIV_W)) u_post1 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .tick_in  (vco_en),
    .half_in  (1'b1),
    .modulus  (np1),
    .tick_out (p1_tick),
    .level    (p1_level)
  );

  // RL2: stage two counts stage one wraps
  pda_div_stage #(.W(`PDA_DIV_W)) u_post2 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .tick_in  (p1_tick),
    .half_in  (p1_level),
    .modulus  (np2),
    .tick_out (p2_tick),
    .level    (p2_level)
  );

  // RL3: last stage sets the output duty
  pda_div_stage #(.W(`PDA_DIV_W)) u_post3 (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .tick_in  (p2_tick),
    .half_in  (p2_level),
    .modulus  (np3),
    .tick_out (p3_tick),
    .level    (out_level)
  );

  // RL6: feedback source mux
  assign fb_src_tick = feedback_source_select ? p3_tick : 1'b1;  // VCO side is ahead of the swallower

  // Feedback divider; its wrap is the feedback-source clock event
  pda_div_stage #(.W(`PDA_FB_W)) u_fbdiv (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .tick_in  (fb_src_tick),
    .half_in  (feedback_source_select ? out_level : 1'b1),
    .modulus  (nfb),
    .tick_out (fb_tick),
    .level    (fb_level)
  );

  // Status value shown on the pin and, except in the feedback monitor mode, in the upper select bit
  always_comb begin
    case (stat_mode)
      // RL18: lock status level
      pda_pkg::PDA_MODE_LOCK:  status_bit = xtal_lock_ok;
      // RL19: out-of-range direction
      pda_pkg::PDA_MODE_RANGE: status_bit = xtal_range_high;
      // RL11: alignment flag mode
      pda_pkg::PDA_MODE_ALIGN: status_bit = s_q.align_flag;
      // RL14: feedback divider clock
      pda_pkg::PDA_MODE_FBMON: status_bit = fb_level;
      default:                 status_bit = 1'b0;
    endcase
  end

  // Readback views of control and status
  always_comb begin
    ctrl_rd = s_q.ctrl;
    // RL13: flag replaces upper bit
    if (stat_mode != pda_pkg::PDA_MODE_FBMON) begin
      ctrl_rd[`PDA_CTRL_STAT_HI] = status_bit;
    end
    status_rd                  = '0;
    status_rd[`PDA_STS_ALIGN]  = s_q.align_flag;
    status_rd[`PDA_STS_FBCLK]  = fb_level;
    status_rd[`PDA_STS_OUTCLK] = out_level;
    status_rd[`PDA_STS_PIN]    = lock_status_pin_i;
  end

  // Write channel acceptance; address and data may come in either order
  assign aw_take = s_axi_awvalid && s_q.awready;
  assign w_take  = s_axi_wvalid && s_q.wready;
  assign have_aw = s_q.aw_held || aw_take;
  assign have_w  = s_q.w_held || w_take;
  assign wr_addr = s_q.aw_held ? s_q.aw_addr : s_axi_awaddr;
  assign wr_data = s_q.w_held ? s_q.w_data : s_axi_wdata;
  assign wr_strb = s_q.w_held ? s_q.w_strb : s_axi_wstrb;

  // Next state of bus slave, registers, sampler and outputs
  always_comb begin
    s_d = s_q;

    // Hold address or data that arrived alone
    if (aw_take) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // Complete a write once both halves are present
    if (have_aw && have_w && !s_q.bvalid) begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = `PDA_RESP_OKAY;
      case (wr_addr)
        `PDA_REG_CTRL:   s_d.ctrl  = merge_bytes(s_q.ctrl, wr_data, wr_strb,
                                                 `PDA_CTRL_MASK);
        `PDA_REG_DIV:    s_d.div   = merge_bytes(s_q.div, wr_data, wr_strb,
                                                 `PDA_DIV_MASK);
        `PDA_REG_FBDIV:  s_d.fbdiv = merge_bytes(s_q.fbdiv, wr_data, wr_strb,
                                                 `PDA_FBDIV_MASK);
        `PDA_REG_STATUS: s_d.bresp = `PDA_RESP_OKAY;
        default:         s_d.bresp = `PDA_RESP_SLVERR;
      endcase
    end
    s_d.awready = !s_d.aw_held && !s_d.bvalid;
    s_d.wready  = !s_d.w_held && !s_d.bvalid;

    // Read channel: one read at a time, answered the cycle after the address
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = `PDA_RESP_OKAY;
      case (s_axi_araddr)
        `PDA_REG_CTRL:   s_d.rdata = ctrl_rd;
        `PDA_REG_DIV:    s_d.rdata = s_q.div;
        `PDA_REG_FBDIV:  s_d.rdata = s_q.fbdiv;
        `PDA_REG_STATUS: s_d.rdata = status_rd;
        default: begin
          s_d.rdata = '0;
          s_d.rresp = `PDA_RESP_SLVERR;
        end
      endcase
    end
    s_d.arready = !s_d.rvalid;

    // RL9: sample output on feedback clock
    if (fb_tick) begin
      // RL8: flag follows the sampled phase
      s_d.align_flag = out_level;
    end

    // RL12: status value onto the pin
    s_d.pin_o = status_bit;
    // RL15: drive only when enabled
    s_d.pin_oe = pushpull_en;

    // Differential output from the last post divider stage
    s_d.clk_p = out_level;
    s_d.clk_n = !out_level;

    // RL16: coarse load code
    s_d.coarse = s_q.ctrl[`PDA_CTRL_COARSE +: `PDA_COARSE_W];
    // RL17: fine tune enable
    s_d.fine_en = s_q.ctrl[`PDA_CTRL_FINE_EN];
  end

  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q       <= '0;
      s_q.ctrl  <= `PDA_CTRL_RST;
      s_q.div   <= `PDA_DIV_RST;
      s_q.fbdiv <= `PDA_FBDIV_RST;
      s_q.clk_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Ports straight from the state register
  assign s_axi_awready            = s_q.awready;
  assign s_axi_wready             = s_q.wready;
  assign s_axi_bvalid             = s_q.bvalid;
  assign s_axi_bresp              = s_q.bresp;
  assign s_axi_arready            = s_q.arready;
  assign s_axi_rvalid             = s_q.rvalid;
  assign s_axi_rdata              = s_q.rdata;
  assign s_axi_rresp              = s_q.rresp;
  assign lock_status_pin_o        = s_q.pin_o;
  assign lock_status_pin_oe       = s_q.pin_oe;
  assign differential_clock_out_p = s_q.clk_p;
  assign differential_clock_out_n = s_q.clk_n;
  assign crystal_coarse_tune_code = s_q.coarse;
  assign crystal_fine_tune_enable = s_q.fine_en;

endmodule

`default_nettype wire

// *** src/pda_params.svh ***
// Register offsets, field positions, reset values and widths of the post divider block
`ifndef PDA_PARAMS_SVH
`define PDA_PARAMS_SVH

`define PDA_ADDR_W        4
`define PDA_DATA_W        32
`define PDA_DIV_W         8
`define PDA_FB_W          14
`define PDA_COARSE_W      4

`define PDA_REG_CTRL      4'h0
`define PDA_REG_DIV       4'h4
`define PDA_REG_FBDIV     4'h8
`define PDA_REG_STATUS    4'hC

`define PDA_CTRL_SWALLOW  0
`define PDA_CTRL_FBSEL    1
`define PDA_CTRL_PUSHPULL 2
`define PDA_CTRL_STAT_LO  3
`define PDA_CTRL_STAT_HI  4
`define PDA_CTRL_COARSE   8
`define PDA_CTRL_FINE_EN  12
`define PDA_CTRL_MASK     32'h0000_1F1F

`define PDA_DIV_P1        0
`define PDA_DIV_P2        8
`define PDA_DIV_P3        16
`define PDA_DIV_MASK      32'h00FF_FFFF
`define PDA_FBDIV_MASK    32'h0000_3FFF

`define PDA_STS_ALIGN     0
`define PDA_STS_FBCLK     1
`define PDA_STS_OUTCLK    2
`define PDA_STS_PIN       3

`define PDA_CTRL_RST      32'h0000_0000
`define PDA_DIV_RST       32'h0001_0101
`define PDA_FBDIV_RST     32'h0000_0001

`define PDA_RESP_OKAY     2'h0
`define PDA_RESP_SLVERR   2'h2

`endif

// *** src/pda_pkg.sv ***
// Types shared by the post divider and phase alignment block
`include "pda_params.svh"

package pda_pkg;

  // Status pin modes in the order of their two-bit select code
  typedef enum logic [1:0] {
    PDA_MODE_LOCK,
    PDA_MODE_RANGE,
    PDA_MODE_ALIGN,
    PDA_MODE_FBMON
  } pda_stat_mode_t;

  // Whole state of the top module
  typedef struct packed {
    logic                          aw_held;
    logic [`PDA_ADDR_W-1:0]        aw_addr;
    logic                          w_held;
    logic [`PDA_DATA_W-1:0]        w_data;
    logic [`PDA_DATA_W/8-1:0]      w_strb;
    logic                          awready;
    logic                          wready;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          arready;
    logic                          rvalid;
    logic [`PDA_DATA_W-1:0]        rdata;
    logic [1:0]                    rresp;
    logic [`PDA_DATA_W-1:0]        ctrl;
    logic [`PDA_DATA_W-1:0]        div;
    logic [`PDA_DATA_W-1:0]        fbdiv;
    logic                          align_flag;
    logic                          pin_o;
    logic                          pin_oe;
    logic                          clk_p;
    logic                          clk_n;
    logic [`PDA_COARSE_W-1:0]      coarse;
    logic                          fine_en;
  } pda_state_t;

endpackage

// *** src/pda_div_stage.sv ***
// One programmable divider stage counting enable ticks, with near half duty level
`timescale 1ns/1ps
`default_nettype none

module pda_div_stage #(
  parameter int W = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         tick_in,
  input  wire logic         half_in,  // High in the first half of one input tick
  input  wire logic [W-1:0] modulus,
  output logic              tick_out,
  output logic              level
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
    logic         level;
  } pda_stage_t;

  pda_stage_t s_q;
  pda_stage_t s_d;
  logic [W-1:0] eff;
  logic [W-1:0] half;

  // Modulus zero acts as one; an odd modulus splits its middle input tick by half_in
  always_comb begin
    eff  = (modulus == '0) ? W'(1) : modulus;
    half = eff >> 1;
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (tick_in) begin
      if (s_q.cnt >= eff - 1'b1) begin
        s_d.cnt  = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
    // RL3: middle tick split
    s_d.level = (s_d.cnt < half) || (eff[0] && (s_d.cnt == half) && half_in);
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '{cnt: '0, tick: 1'b0, level: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_out = s_q.tick;
  assign level    = s_q.level;

endmodule

`default_nettype wire

// *** src/pda_swallow.sv ***
// Pulse swallower: drops one VCO tick per rising edge of the request bit
`timescale 1ns/1ps
`default_nettype none

module pda_swallow (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic request,
  output logic      vco_en
);

  typedef struct packed {
    logic req;
    logic en;
  } pda_swallow_t;

  pda_swallow_t s_q;
  pda_swallow_t s_d;

  // Edge detect on the request level; the tick after a rise is withheld
  always_comb begin
    s_d.req = request;
    // RL20: rise detect once
    s_d.en = !(request && !s_q.req);
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '{req: 1'b0, en: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // RL5: one tick gap
  assign vco_en = s_q.en;

endmodule

`default_nettype wire

// *** dv/pda_top_sva.sv ***
// Port-level assertions for the post divider block
`timescale 1ns/1ps
`default_nettype none
`include "pda_params.svh"

module pda_top_sva (
  input wire logic                     aclk,
  input wire logic                     aresetn,
  input wire logic [`PDA_ADDR_W-1:0]   s_axi_awaddr,
  input wire logic                     s_axi_awvalid,
  input wire logic                     s_axi_awready,
  input wire logic [`PDA_DATA_W-1:0]   s_axi_wdata,
  input wire logic [`PDA_DATA_W/8-1:0] s_axi_wstrb,
  input wire logic                     s_axi_wvalid,
  input wire logic                     s_axi_wready,
  input wire logic [1:0]               s_axi_bresp,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic [`PDA_ADDR_W-1:0]   s_axi_araddr,
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic [`PDA_DATA_W-1:0]   s_axi_rdata,
  input wire logic [1:0]               s_axi_rresp,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready,
  input wire logic                     differential_clock_out_p,
  input wire logic                     differential_clock_out_n,
  input wire logic [`PDA_COARSE_W-1:0] crystal_coarse_tune_code,
  input wire logic                     crystal_fine_tune_enable
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Complementary clock pair, bus answers and how long they stand
  chk_clk_pair: assert property (differential_clock_out_n == !differential_clock_out_p)
    else $error("clock outputs not complementary");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write response late");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  chk_r_slverr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
    |=> s_axi_rresp == `PDA_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
  chk_b_excl: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while response pending");
  chk_r_excl: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready while data pending");
  // Crystal tuning outputs follow a control write two edges later
  chk_coarse_code: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[1]
    && s_axi_awaddr == `PDA_REG_CTRL |-> ##2 crystal_coarse_tune_code == $past(s_axi_wdata[11:8], 2))
    else $error("coarse code not applied");
  chk_fine_enable: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[1]
    && s_axi_awaddr == `PDA_REG_CTRL |-> ##2 crystal_fine_tune_enable == $past(s_axi_wdata[12], 2))
    else $error("fine enable not applied");
endmodule
`default_nettype wire

// *** dv/pda_far_end.sv ***
// Far side model: crystal loop status source and the status pin wire
`timescale 1ns/1ps
`default_nettype none

module pda_far_end (
  input wire logic aclk,
  input wire logic lock_cmd,
  input wire logic range_cmd,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic     lock_ok,
  output logic     range_high,
  output logic     pin_i
);
  logic scramble_q = 1'b0;

  // Loop status lags the bench command; undriven pin shows a changing level
  always_ff @(posedge aclk) begin
    lock_ok <= lock_cmd;
    range_high <= range_cmd;
    scramble_q <= !scramble_q;
  end

  // Pin has no pull, so a released pin must not look like the last value
  assign pin_i = pin_oe ? pin_o : scramble_q;
endmodule
`default_nettype wire

// *** dv/test_pda_top.sv ***
// Self-checking bench for the post divider and phase alignment block
`timescale 1ns/1ps
`default_nettype none
`include "pda_params.svh"

module test_pda_top;
  typedef struct {logic [1:0] resp; logic [31:0] data; logic [31:0] mask;} pda_note_t;
  typedef struct {int hi; int lo;} pda_run_t;
  logic        aclk = 1'b0, aresetn = 1'b0, lock_cmd = 1'b1, range_cmd = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, coarse;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rng = 32'h0000_DDDA, got, v;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, pin_i, pin_o, pin_oe, lock_ok;
  logic        range_high, clk_p, clk_n, fine, lvl, started = 1'b0, f;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          fails = 0, n_compared = 0, run = 0, n;
  pda_note_t   note_q[$], nt;
  pda_run_t    run_q[$];

  always #20 aclk = ~aclk;

  pda_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .xtal_lock_ok(lock_ok), .xtal_range_high(range_high),
    .lock_status_pin_i(pin_i), .lock_status_pin_o(pin_o), .lock_status_pin_oe(pin_oe),
    .differential_clock_out_p(clk_p), .differential_clock_out_n(clk_n),
    .crystal_coarse_tune_code(coarse), .crystal_fine_tune_enable(fine));

  pda_far_end far (.aclk, .lock_cmd, .range_cmd, .pin_o, .pin_oe, .lock_ok, .range_high, .pin_i);

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Write with both halves offered together, waiting for the response
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    note_q.push_back('{r, 32'h0, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 60);
    s_axi_bready <= 1'b0;
    if (n >= 60) begin
      fails++;
      tally_and_finish();
    end
  endtask

  // Read one word, noting the expected masked data and response
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m,
                        input logic [1:0] r);
    note_q.push_back('{r, e & m, m});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 60);
    got = s_axi_rdata;
    s_axi_rready <= 1'b0;
    if (n >= 60) begin
      fails++;
      tally_and_finish();
    end
  endtask

  // Takes the oldest note at each bus answer and compares it
  always @(posedge aclk) begin
    if (aresetn && ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))) begin
      if (note_q.size() == 0) check("unexpected answer", 32'h1, 32'h0);
      else begin
        nt = note_q.pop_front();
        check("resp", {30'h0, s_axi_bvalid ? s_axi_bresp : s_axi_rresp}, {30'h0, nt.resp});
        check("rdata", s_axi_rdata & nt.mask, nt.data);
      end
    end
  end

  // Measures high and low stretches of the output clock against queued lengths
  always @(posedge aclk) begin
    if (clk_p !== lvl) begin
      if (started && run_q.size() > 0) begin
        check("clock run", run, lvl ? run_q[0].hi : run_q[0].lo);
        if (!lvl) void'(run_q.pop_front());
      end
      started = (run_q.size() != 0);
      lvl = clk_p;
      run = 1;
    end else run++;
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // reset values, live lock bit, unmapped read
    axi_rd(`PDA_REG_CTRL, 32'h10, 32'hFFFF_FFFF, `PDA_RESP_OKAY);
    axi_rd(`PDA_REG_DIV, `PDA_DIV_RST, 32'hFFFF_FFFF, `PDA_RESP_OKAY);
    axi_rd(`PDA_REG_FBDIV, `PDA_FBDIV_RST, 32'hFFFF_FFFF, `PDA_RESP_OKAY);
    axi_rd(4'h5, 32'h0, 32'hFFFF_FFFF, `PDA_RESP_SLVERR);
    axi_wr(4'h6, rnd(), `PDA_RESP_SLVERR);
    axi_wr(`PDA_REG_STATUS, rnd(), `PDA_RESP_OKAY);
    // each status mode on the driven pin
    for (int m = 0; m < 4; m++) begin
      v = rnd();
      lock_cmd <= v[0];
      range_cmd <= v[1];
      axi_wr(`PDA_REG_CTRL, 32'h4 | (m << 3), `PDA_RESP_OKAY);
      f = (m == 0) ? v[0] : (m == 1) ? v[1] : 1'b1;
      axi_rd(`PDA_REG_STATUS, {28'h0, f, 3'h0}, 32'h8, `PDA_RESP_OKAY);
      axi_rd(`PDA_REG_CTRL, {27'h0, f, m[0], 3'h4}, 32'h1F, `PDA_RESP_OKAY);
    end
    repeat (4) begin
      v = rnd() & 32'h1F00;
      axi_wr(`PDA_REG_CTRL, v, `PDA_RESP_OKAY);
      axi_rd(`PDA_REG_CTRL, v, 32'h1F00, `PDA_RESP_OKAY);
    end
    // stage cascades with odd moduli, stretch lengths
    for (int c = 0; c < 2; c++) begin
      axi_wr(`PDA_REG_DIV, c ? 32'h0002_0203 : 32'h0003_0202, `PDA_RESP_OKAY);
      repeat (40) @(posedge aclk);
      repeat (2) run_q.push_back('{6, 6});
      for (n = 0; n < 400 && run_q.size() > 0; n++) @(posedge aclk);
      if (run_q.size() > 0) begin
        fails++;
        tally_and_finish();
      end
    end
    // one slip per step flips the flag, except with the divider in the loop
    axi_wr(`PDA_REG_DIV, 32'h0002_0101, `PDA_RESP_OKAY);
    axi_wr(`PDA_REG_FBDIV, 32'h2, `PDA_RESP_OKAY);
    for (int s = 0; s < 4; s++) begin
      v = (s == 3) ? 32'h16 : 32'h14;
      axi_wr(`PDA_REG_CTRL, v, `PDA_RESP_OKAY);
      repeat (8) @(posedge aclk);
      axi_rd(`PDA_REG_STATUS, 32'h0, 32'h0, `PDA_RESP_OKAY);
      f = got[0] ^ (s != 3);
      axi_wr(`PDA_REG_CTRL, v | 32'h1, `PDA_RESP_OKAY);
      repeat (8) @(posedge aclk);
      axi_rd(`PDA_REG_STATUS, {28'h0, f, 2'h0, f}, 32'h9, `PDA_RESP_OKAY);
      axi_rd(`PDA_REG_CTRL, {27'h0, f, 2'h1, v[1], 1'b1}, 32'h1F, `PDA_RESP_OKAY);
    end
    tally_and_finish();
  end
endmodule

bind pda_top pda_top_sva chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .differential_clock_out_p, .differential_clock_out_n,
  .crystal_coarse_tune_code, .crystal_fine_tune_enable);
`default_nettype wire
